/* common/wmi_pkg.sv */
// Purpose: Shared constants for the wake/measurement/interrupt block
// Assumes: 100 MHz core clock, Avalon-MM word registers
// Notes: Times are kept in microseconds; cycle counts derive from them
package wmi_pkg;
    // Clock and timing
    localparam int CLK_MHZ = 100;
    localparam int T_PULSE_US = 100;
    localparam int T_GAP_US = 100;
    localparam int T_FLT_SHORT_US = 16;
    localparam int T_FLT_LONG_US = 64;
    localparam int PULSE_CYC = T_PULSE_US * CLK_MHZ;
    localparam int GAP_CYC = T_GAP_US * CLK_MHZ;
    localparam int FLT_SHORT_CYC = T_FLT_SHORT_US * CLK_MHZ;
    localparam int FLT_LONG_CYC = T_FLT_LONG_US * CLK_MHZ;
    localparam int CNT_W = 16;

    // Channels: three wake pins, then two general-purpose wake pins
    localparam int N_WAKE_PIN = 3;
    localparam int N_GPIO = 2;
    localparam int N_CH = N_WAKE_PIN + N_GPIO;
    localparam int N_FAIL = 8;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MODE = 8'h04;
    localparam logic [7:0] REG_WAKE_SRC_EN = 8'h08;
    localparam logic [7:0] REG_WAKE_PULL = 8'h0c;
    localparam logic [7:0] REG_WAKE_FILT = 8'h10;
    localparam logic [7:0] REG_WAKE_STAT_A = 8'h14;
    localparam logic [7:0] REG_WAKE_STAT_B = 8'h18;
    localparam logic [7:0] REG_PIN_LEVEL = 8'h1c;
    localparam logic [7:0] REG_FAIL_STAT = 8'h20;
    localparam logic [7:0] REG_ERR_STAT = 8'h24;

    // Field positions
    localparam int CTRL_MEAS_BIT = 0;
    localparam int CTRL_GLOBAL_BIT = 1;
    localparam int ERR_CMD_BIT = 0;

    // Reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [2:0] WAKE_EN_RST = 3'h0;
    localparam logic [5:0] CFG6_RST = 6'h00;

    // Pull and filter codes (two bits per pin)
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;
    localparam logic [1:0] PULL_AUTO = 2'h3;
    localparam logic [1:0] FILT_LONG = 2'h1;

    typedef enum logic [2:0] {
        MODE_INIT = 3'h0,
        MODE_NORMAL = 3'h1,
        MODE_STOP = 3'h3,
        MODE_SLEEP = 3'h2,
        MODE_RESTART = 3'h6
    } wmi_mode_e;

    typedef enum logic [1:0] {
        IRQ_IDLE = 2'h0,
        IRQ_LOW = 2'h1,
        IRQ_GAP = 2'h3
    } wmi_irq_e;
endpackage : wmi_pkg

/* logic/wmi_wake_filter.sv */
// Purpose: Per-channel wake edge filter with selectable settle time
// Assumes: Levels arrive already synchronised to clk_i
// Notes: Gated channels track their input silently, so no event on release
`timescale 1ns/1ps
module wmi_wake_filter #(
    parameter int N = wmi_pkg::N_CH,
    parameter int SHORT_CYC = wmi_pkg::FLT_SHORT_CYC,
    parameter int LONG_CYC = wmi_pkg::FLT_LONG_CYC
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [N-1:0] level_i,
    input wire logic [N-1:0] long_sel_i,
    input wire logic [N-1:0] gate_i,
    output logic [N-1:0] stable_o,
    output logic [N-1:0] event_o
);
    import wmi_pkg::*;

    localparam logic [CNT_W-1:0] LIM_S = CNT_W'(SHORT_CYC - 1);
    localparam logic [CNT_W-1:0] LIM_L = CNT_W'(LONG_CYC - 1);

    for (genvar g = 0; g < N; g++) begin : g_ch
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] next_cnt;
        logic stable;
        logic next_stable;
        logic ev;
        logic next_ev;

        always_comb begin
            next_cnt = '0;
            next_stable = stable;
            next_ev = 1'b0;
            if (gate_i[g]) begin
                next_stable = level_i[g];
            end else if (level_i[g] != stable) begin
                // Both directions count as wake edges
                if (cnt >= (long_sel_i[g] ? LIM_L : LIM_S)) begin
                    next_stable = level_i[g];
                    next_ev = 1'b1;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            // Crossing back leaves next_cnt at zero and restarts timing
        end

        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                cnt <= '0;
                stable <= 1'b0;
                ev <= 1'b0;
            end else if (ce_i) begin
                cnt <= next_cnt;
                stable <= next_stable;
                ev <= next_ev;
            end
        end

        assign stable_o[g] = stable;
        assign event_o[g] = ev;
    end
endmodule : wmi_wake_filter

/* logic/wmi_wake_irq.sv */
// Purpose: Wake filtering, measurement path gating and interrupt pulser
// Assumes: Avalon-MM slave, one wait state; pins enter through 2 flops
// Notes: Status shown to software is refreshed when a pulse begins
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module wmi_wake_irq #(
    parameter int PULSE_CYC = wmi_pkg::PULSE_CYC,
    parameter int GAP_CYC = wmi_pkg::GAP_CYC,
    parameter int FLT_SHORT_CYC = wmi_pkg::FLT_SHORT_CYC,
    parameter int FLT_LONG_CYC = wmi_pkg::FLT_LONG_CYC
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [wmi_pkg::N_WAKE_PIN-1:0] wake_pin_i,
    input wire logic [wmi_pkg::N_GPIO-1:0] gpio_wake_pin_i,
    input wire logic [wmi_pkg::N_GPIO-1:0] gpio_is_wake_i,
    input wire logic [wmi_pkg::N_FAIL-1:0] fail_event_i,
    input wire logic int_pin_i,
    output logic int_pin_o,
    output logic int_pin_oe_n_o,
    output logic cfg_select_o,
    output logic meas_switch_o,
    output logic [wmi_pkg::N_WAKE_PIN-1:0] pull_up_o,
    output logic [wmi_pkg::N_WAKE_PIN-1:0] pull_down_o,
    output logic [2:0] mode_o
);
    import wmi_pkg::*;

    localparam logic [CNT_W-1:0] PULSE_LIM = CNT_W'(PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_LIM = CNT_W'(GAP_CYC - 1);

    // Pin synchronisers: first stage feeds only the second
    logic [N_CH:0] sync1;
    logic [N_CH:0] sync2;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync1 <= '0;
            sync2 <= '0;
        end else if (ce_i) begin
            sync1 <= {int_pin_i, gpio_wake_pin_i, wake_pin_i};
            sync2 <= sync1;
        end
    end

    // Configuration and mode state
    logic meas_path_enable;
    logic int_global;
    logic [N_WAKE_PIN-1:0] wake_source_enable_reg;
    logic [5:0] wake_pull_config;
    logic [5:0] wake_filter_config;
    wmi_mode_e mode;
    logic cmd_err;
    logic next_meas;
    logic next_global;
    logic [N_WAKE_PIN-1:0] next_wake_en;
    logic [5:0] next_pull;
    logic [5:0] next_filt;
    wmi_mode_e next_mode;
    logic next_cmd_err;

    // Bus slave
    logic wait_q;
    logic [31:0] rdata;
    logic next_wait;
    logic [31:0] next_rdata;
    logic [31:0] rd_mux;
    logic wr_en;
    logic mode_wr;
    logic only_first_two;
    logic [N_CH-1:0] vis;
    logic [N_CH-1:0] lvl;
    logic [N_FAIL-1:0] fvis;

    assign wr_en = avs_write_i & ~wait_q & avs_byteenable_i[0];
    assign mode_wr = wr_en & (avs_address_i == REG_MODE);

    always_comb begin
        rd_mux = '0;
        unique case (avs_address_i)
            REG_CTRL: rd_mux[1:0] = {int_global, meas_path_enable};
            REG_MODE: rd_mux[2:0] = mode;
            REG_WAKE_SRC_EN: rd_mux[N_WAKE_PIN-1:0] = wake_source_enable_reg;
            REG_WAKE_PULL: rd_mux[5:0] = wake_pull_config;
            REG_WAKE_FILT: rd_mux[5:0] = wake_filter_config;
            REG_WAKE_STAT_A: rd_mux[N_WAKE_PIN-1:0] = vis[N_WAKE_PIN-1:0];
            REG_WAKE_STAT_B: rd_mux[N_GPIO-1:0] = vis[N_CH-1:N_WAKE_PIN];
            REG_PIN_LEVEL: rd_mux[N_CH-1:0] = lvl;
            REG_FAIL_STAT: rd_mux[N_FAIL-1:0] = fvis;
            REG_ERR_STAT: rd_mux[ERR_CMD_BIT] = cmd_err;
            default: rd_mux = '0;
        endcase
    end

    always_comb begin
        next_wait = 1'b1;
        next_rdata = rdata;
        if (wait_q && (avs_read_i || avs_write_i)) begin
            next_wait = 1'b0;
            next_rdata = avs_read_i ? rd_mux : '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wait_q <= 1'b1;
            rdata <= '0;
        end else if (ce_i) begin
            wait_q <= next_wait;
            rdata <= next_rdata;
        end
    end
    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o = rdata;

    // Sleep refused when the measured pins are the only wake sources
    assign only_first_two = (|wake_source_enable_reg[1:0])
        & ~wake_source_enable_reg[2] & ~(|gpio_is_wake_i);

    always_comb begin
        next_meas = meas_path_enable;
        next_global = int_global;
        next_wake_en = wake_source_enable_reg;
        next_pull = wake_pull_config;
        next_filt = wake_filter_config;
        next_mode = mode;
        next_cmd_err = cmd_err;
        if (wr_en && avs_address_i == REG_CTRL) begin
            next_meas = avs_writedata_i[CTRL_MEAS_BIT];
            next_global = avs_writedata_i[CTRL_GLOBAL_BIT];
        end
        // Stored even while measuring; gating makes bits 0 and 1 inert
        if (wr_en && avs_address_i == REG_WAKE_SRC_EN) begin
            next_wake_en = avs_writedata_i[N_WAKE_PIN-1:0];
        end
        if (wr_en && avs_address_i == REG_WAKE_PULL) begin
            next_pull = avs_writedata_i[5:0];
        end
        if (wr_en && avs_address_i == REG_WAKE_FILT) begin
            next_filt = avs_writedata_i[5:0];
        end
        if (wr_en && avs_address_i == REG_ERR_STAT
            && avs_writedata_i[ERR_CMD_BIT]) begin
            next_cmd_err = 1'b0;
        end
        // Mode moves only on a command, never on an interrupt
        if (mode_wr) begin
            unique case (avs_writedata_i[2:0])
                MODE_NORMAL, MODE_STOP, MODE_RESTART, MODE_INIT: begin
                    next_mode = wmi_mode_e'(avs_writedata_i[2:0]);
                end
                MODE_SLEEP: begin
                    if (meas_path_enable && only_first_two) begin
                        next_mode = MODE_RESTART;
                        next_cmd_err = 1'b1;
                    end else begin
                        next_mode = MODE_SLEEP;
                    end
                end
                default: next_cmd_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meas_path_enable <= CTRL_RST[CTRL_MEAS_BIT];
            int_global <= CTRL_RST[CTRL_GLOBAL_BIT];
            wake_source_enable_reg <= WAKE_EN_RST;
            wake_pull_config <= CFG6_RST;
            wake_filter_config <= CFG6_RST;
            mode <= MODE_INIT;
            cmd_err <= 1'b0;
        end else if (ce_i) begin
            meas_path_enable <= next_meas;
            int_global <= next_global;
            wake_source_enable_reg <= next_wake_en;
            wake_pull_config <= next_pull;
            wake_filter_config <= next_filt;
            mode <= next_mode;
            cmd_err <= next_cmd_err;
        end
    end

    // Wake filtering and channel gating
    logic [N_CH-1:0] long_sel;
    logic [N_CH-1:0] gate;
    logic [N_CH-1:0] stable;
    logic [N_CH-1:0] wake_ev;
    logic [N_CH-1:0] src_en;
    for (genvar g = 0; g < N_WAKE_PIN; g++) begin : g_pin
        assign long_sel[g] = wake_filter_config[2*g+:2] == FILT_LONG;
    end
    assign long_sel[N_CH-1:N_WAKE_PIN] = '0;
    assign gate = {~gpio_is_wake_i, 1'b0,
        {2{meas_path_enable}}};
    assign src_en = {gpio_is_wake_i, wake_source_enable_reg};

    wmi_wake_filter #(
        .N(N_CH),
        .SHORT_CYC(FLT_SHORT_CYC),
        .LONG_CYC(FLT_LONG_CYC)
    ) u_filter (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .level_i(sync2[N_CH-1:0]),
        .long_sel_i(long_sel),
        .gate_i(gate),
        .stable_o(stable),
        .event_o(wake_ev)
    );

    // Status latches, level register and pad controls
    wmi_irq_e state;
    logic pend;
    logic start;
    logic snap_upd;
    logic [N_CH-1:0] raw;
    logic [N_FAIL-1:0] fraw;
    logic [N_CH-1:0] clr_w;
    logic [N_FAIL-1:0] clr_f;
    logic [N_CH-1:0] next_raw;
    logic [N_CH-1:0] next_vis;
    logic [N_CH-1:0] next_lvl;
    logic [N_FAIL-1:0] next_fraw;
    logic [N_FAIL-1:0] next_fvis;
    logic [N_WAKE_PIN-1:0] next_pu;
    logic [N_WAKE_PIN-1:0] next_pd;
    logic irq_ev;
    logic act_mode;

    assign act_mode = (mode == MODE_NORMAL) || (mode == MODE_STOP);
    assign start = (state == IRQ_IDLE) && pend && act_mode;
    // Software view follows raw when idle with no pulse owed or when a pulse begins
    assign snap_upd = start || (state == IRQ_IDLE && !pend);

    always_comb begin
        clr_w = '0;
        clr_f = '0;
        if (wr_en && avs_address_i == REG_WAKE_STAT_A) begin
            clr_w[N_WAKE_PIN-1:0] = avs_writedata_i[N_WAKE_PIN-1:0];
        end
        if (wr_en && avs_address_i == REG_WAKE_STAT_B) begin
            clr_w[N_CH-1:N_WAKE_PIN] = avs_writedata_i[N_GPIO-1:0];
        end
        if (wr_en && avs_address_i == REG_FAIL_STAT) begin
            clr_f = avs_writedata_i[N_FAIL-1:0];
        end
        // New events beat a clear in the same cycle
        next_raw = (raw & ~clr_w) | wake_ev;
        next_fraw = (fraw & ~clr_f) | fail_event_i;
        next_vis = snap_upd ? (raw & ~clr_w) : (vis & ~clr_w);
        next_fvis = snap_upd ? (fraw & ~clr_f) : (fvis & ~clr_f);
        next_lvl = lvl;
        if (act_mode) begin
            next_lvl = stable | (sync2[N_CH-1:0] & gate);
            if (meas_path_enable) begin
                next_lvl[1:0] = lvl[1:0];
            end
        end
        for (int i = 0; i < N_WAKE_PIN; i++) begin
            next_pu[i] = wake_pull_config[2*i+:2] == PULL_UP
                || (wake_pull_config[2*i+:2] == PULL_AUTO && stable[i]);
            next_pd[i] = wake_pull_config[2*i+:2] == PULL_DOWN
                || (wake_pull_config[2*i+:2] == PULL_AUTO && !stable[i]);
        end
        if (meas_path_enable) begin
            next_pu[1:0] = '0;
            next_pd[1:0] = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            raw <= '0;
            vis <= '0;
            lvl <= '0;
            fraw <= '0;
            fvis <= '0;
            pull_up_o <= '0;
            pull_down_o <= '0;
            meas_switch_o <= 1'b0;
            mode_o <= MODE_INIT;
        end else if (ce_i) begin
            raw <= next_raw;
            vis <= next_vis;
            lvl <= next_lvl;
            fraw <= next_fraw;
            fvis <= next_fvis;
            pull_up_o <= next_pu;
            pull_down_o <= next_pd;
            meas_switch_o <= next_meas && (next_mode == MODE_NORMAL);
            mode_o <= next_mode;
        end
    end

    // Interrupt pulser
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    wmi_irq_e next_state;
    logic next_pend;
    logic next_pin;
    logic next_oe_n;
    logic next_cfg;

    // Failures only in global class; restart-class flags never wired here
    assign irq_ev = |(wake_ev & src_en & ~gate)
        || (int_global && |fail_event_i)
        || (mode_wr && avs_writedata_i[2:0] == MODE_STOP
            && |vis);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_pin = int_pin_o;
        next_pend = (pend && !start) || irq_ev;
        next_oe_n = (mode == MODE_INIT);
        next_cfg = (mode == MODE_INIT) ? sync2[N_CH] : cfg_select_o;
        unique case (state)
            IRQ_IDLE: begin
                if (start) begin
                    next_state = IRQ_LOW;
                    next_cnt = '0;
                    next_pin = 1'b0;
                end
            end
            IRQ_LOW: begin
                next_cnt = cnt + 1'b1;
                if (cnt == PULSE_LIM) begin
                    next_state = IRQ_GAP;
                    next_cnt = '0;
                    next_pin = 1'b1;
                end
            end
            IRQ_GAP: begin
                next_cnt = cnt + 1'b1;
                if (cnt == GAP_LIM) begin
                    next_state = IRQ_IDLE;
                end
            end
            default: begin
                next_state = IRQ_IDLE;
                next_pin = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= IRQ_IDLE;
            cnt <= '0;
            pend <= 1'b0;
            int_pin_o <= 1'b1;
            int_pin_oe_n_o <= 1'b1;
            cfg_select_o <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            cnt <= next_cnt;
            pend <= next_pend;
            int_pin_o <= next_pin;
            int_pin_oe_n_o <= next_oe_n;
            cfg_select_o <= next_cfg;
        end
    end

    // Checks
    logic [CNT_W-1:0] low_len;
    logic [CNT_W-1:0] high_len;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            low_len <= '0;
            high_len <= '1;
        end else if (ce_i) begin
            low_len <= int_pin_o ? '0 : low_len + 1'b1;
            if (!int_pin_o) begin
                high_len <= '0;
            end else if (high_len != '1) begin
                high_len <= high_len + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_meas_reset_open: assert property (
        $past(sys_rst_i) |-> !meas_switch_o && !meas_path_enable)
        else $error("measurement path not off after reset");
    chk_meas_switch_mode: assert property (
        meas_switch_o |-> meas_path_enable && mode == MODE_NORMAL)
        else $error("measurement switch closed outside Normal");
    chk_meas_pull_off: assert property (
        ce_i && meas_path_enable && next_meas |=>
            pull_up_o[1:0] == 2'b00 && pull_down_o[1:0] == 2'b00)
        else $error("pull source active while measuring");
    chk_meas_level_hold: assert property (
        ce_i && meas_path_enable |=> lvl[1:0] == $past(lvl[1:0]))
        else $error("level status moved while measuring");
    chk_sleep_refused: assert property (
        ce_i && mode_wr && avs_writedata_i[2:0] == MODE_SLEEP
            && meas_path_enable && only_first_two
            |=> mode == MODE_RESTART && cmd_err)
        else $error("sleep not refused under measurement");
    chk_pulse_width: assert property (
        $rose(int_pin_o) |-> $past(low_len) == PULSE_LIM)
        else $error("interrupt pulse width wrong");
    chk_gap_width: assert property (
        $fell(int_pin_o) |-> $past(high_len) >= CNT_W'(GAP_CYC))
        else $error("interrupt gap too short");
    chk_mode_by_cmd: assert property (
        mode != $past(mode) |-> $past(mode_wr && ce_i))
        else $error("mode changed without a command");
    chk_init_released: assert property (
        ce_i && mode == MODE_INIT |=> int_pin_oe_n_o)
        else $error("interrupt pin driven during Init");
    chk_stop_raises: assert property (
        ce_i && mode_wr && avs_writedata_i[2:0] == MODE_STOP && |vis
            |=> pend || state == IRQ_LOW)
        else $error("stop with wake status gave no interrupt");
endmodule : wmi_wake_irq

/* sim/wake_meas_interrupt_logic_bench.sv */
// Purpose: Self-checking bench for wake, measurement and interrupt logic
// Assumes: Short sim counts 8/8/4/12
// Notes: Bus answer taken at the rising edge where waitrequest is low
`timescale 1ns/1ps
module wake_meas_interrupt_logic_bench;
    import wmi_pkg::*;
    logic clk_i = 0, sys_rst_i = 1, rd = 0, wr = 0, int_i, int_o, oe_n;
    logic [7:0] addr = '0, np;
    logic [31:0] wd = '0, rdat, q;
    logic [2:0] wk = '0, pu, pd, mode;
    logic wait_n, msw;
    logic [15:0] lw, gw;
    int n_mismatch = 0, comparisons = 0;
    logic ce = 1, cfg_hi = 1, cfg;
    logic [3:0] be = 4'hf;
    logic [1:0] gp = '0, gpe = '0;
    logic [7:0] fe = '0;
    always #5 clk_i = ~clk_i;
    wmi_wake_irq #(.PULSE_CYC(8), .GAP_CYC(8), .FLT_SHORT_CYC(4),
        .FLT_LONG_CYC(12)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .ce_i(ce), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_n),
        .wake_pin_i(wk), .gpio_wake_pin_i(gp), .gpio_is_wake_i(gpe),
        .fail_event_i(fe), .int_pin_i(int_i), .int_pin_o(int_o),
        .int_pin_oe_n_o(oe_n), .cfg_select_o(cfg), .meas_switch_o(msw),
        .pull_up_o(pu), .pull_down_o(pd), .mode_o(mode));
    wmi_host_model u_host (.clk_i(clk_i), .int_pin_o(int_o),
        .int_pin_oe_n_o(oe_n), .cfg_hi_i(cfg_hi), .int_pin_i(int_i),
        .n_pulse(np), .low_w(lw), .gap_w(gw));
    task end_sim;
        $display("checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        addr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        // Answer taken at the edge where waitrequest is seen low
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (wait_n === 1'b0) break;
        end
        if (i == 20) begin
            n_mismatch++;
            end_sim();
        end else begin
            q = rdat;
            rd <= 0;
            wr <= 0;
        end
    endtask : bus
    task pulses(input logic [7:0] n);
        logic [7:0] c0;
        c0 = np;
        repeat (60) @(posedge clk_i);
        chk("pulses", n, np - c0);
    endtask : pulses
    task s_reset;
        chk("switch", 0, msw);
        chk("int", 1, int_o);
        bus(0, REG_CTRL, 0);
        chk("ctrl", 0, q);
        bus(0, 8'h3c, 0);
        chk("unmapped", 0, q);
        be <= 4'he;
        bus(1, REG_CTRL, 32'h0000_0002);
        be <= 4'hf;
        bus(0, REG_CTRL, 0);
        chk("ctrl_be", 0, q);
        chk("oe_n", 1, oe_n);
        chk("cfg", 1, cfg);
    endtask : s_reset
    task s_wake;
        bus(1, REG_MODE, 32'(MODE_NORMAL));
        bus(1, REG_WAKE_SRC_EN, 32'h0000_0004);
        chk("oe_n", 0, oe_n);
        wk <= 3'h4;
        repeat (14) @(posedge clk_i);
        wk <= 3'h0;
        pulses(2);
        chk("low", 8, lw);
        chk("gap_ok", 1, gw >= 8);
        chk("mode", MODE_NORMAL, mode);
        bus(0, REG_WAKE_STAT_A, 0);
        chk("stat", 4, q);
        bus(1, REG_WAKE_STAT_A, 32'h0000_0004);
        bus(0, REG_WAKE_STAT_A, 0);
        chk("cleared", 0, q);
        wk <= 3'h4;
        repeat (2) @(posedge clk_i);
        wk <= 3'h0;
        pulses(0);
        // Static long filter; cyclic codes would also need a timer
        bus(1, REG_WAKE_FILT, 32'h0000_0010);
        wk <= 3'h4;
        repeat (10) @(posedge clk_i);
        wk <= 3'h0;
        pulses(0);
        ce <= 0;
        wk <= 3'h4;
        repeat (20) @(posedge clk_i);
        wk <= 3'h0;
        ce <= 1;
        pulses(0);
    endtask : s_wake
    task s_global;
        fe <= 8'h01;
        @(posedge clk_i);
        fe <= 8'h00;
        pulses(0);
        bus(0, REG_FAIL_STAT, 0);
        chk("fail", 1, q);
        bus(1, REG_FAIL_STAT, 32'h0000_0001);
        bus(1, REG_CTRL, 32'h0000_0002);
        fe <= 8'h01;
        @(posedge clk_i);
        fe <= 8'h00;
        pulses(1);
        bus(1, REG_CTRL, 32'h0000_0000);
        gpe <= 2'h1;
        gp <= 2'h1;
        pulses(1);
        bus(0, REG_WAKE_STAT_B, 0);
        chk("stat_b", 1, q);
        bus(1, REG_MODE, 32'(MODE_STOP));
        pulses(1);
        gpe <= 2'h0;
        gp <= 2'h0;
        bus(1, REG_WAKE_STAT_B, 32'h0000_0001);
        bus(1, REG_MODE, 32'(MODE_NORMAL));
    endtask : s_global
    task s_meas;
        bus(1, REG_WAKE_PULL, 32'h0000_0009);
        bus(1, REG_CTRL, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        chk("switch", 1, msw);
        chk("pulls", 0, {pu[1:0], pd[1:0]});
        bus(0, REG_WAKE_PULL, 0);
        chk("pullreg", 9, q);
        bus(1, REG_WAKE_SRC_EN, 32'h0000_0003);
        wk <= 3'h3;
        pulses(0);
        bus(0, REG_WAKE_STAT_A, 0);
        chk("stat", 0, q);
        bus(0, REG_PIN_LEVEL, 0);
        chk("level", 0, q);
        bus(1, REG_MODE, 32'(MODE_SLEEP));
        repeat (3) @(posedge clk_i);
        chk("mode", MODE_RESTART, mode);
        chk("switch", 0, msw);
        bus(0, REG_ERR_STAT, 0);
        chk("err", 1, q);
    endtask : s_meas
    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 0;
        @(posedge clk_i);
        s_reset();
        s_wake();
        s_global();
        s_meas();
        end_sim();
    end
endmodule : wake_meas_interrupt_logic_bench

/* sim/wmi_host_model.sv */
// Purpose: Host side of the interrupt pin, measures pulse and gap widths
// Assumes: Pin level resolved here from drive enable
// Notes: Released pin shows the strap level that selects the config
`timescale 1ns/1ps
module wmi_host_model (
    input wire logic clk_i,
    input wire logic int_pin_o,
    input wire logic int_pin_oe_n_o,
    input wire logic cfg_hi_i,
    output logic int_pin_i,
    output logic [7:0] n_pulse,
    output logic [15:0] low_w,
    output logic [15:0] gap_w
);
    logic prev = 1'b1;
    logic [7:0] cnt = '0;
    logic [15:0] lo = '0;
    logic [15:0] hi = '0;
    // Strap sets the released level; with the strap high, leaving Init gives no false edge
    assign int_pin_i = int_pin_oe_n_o ? cfg_hi_i : int_pin_o;
    assign n_pulse = cnt;
    always @(posedge clk_i) begin
        if (int_pin_i) begin
            hi <= hi + 1'b1;
            lo <= '0;
            if (!prev) begin
                cnt <= cnt + 1'b1;
                low_w <= lo;
            end
        end else begin
            lo <= lo + 1'b1;
            hi <= '0;
            if (prev) gap_w <= hi;
        end
        prev <= int_pin_i;
    end
endmodule : wmi_host_model
